// file: verilog/etb_defs.svh
// register offsets, field positions and limits of the transmit request path
`ifndef ETB_DEFS_SVH
`define ETB_DEFS_SVH
`define ETB_OFF_ISQ      12'h120
`define ETB_OFF_BUS_STATUS    12'h138
`define ETB_OFF_TRANSMIT_COMMAND    12'h144
`define ETB_OFF_TXLEN    12'h146
`define ETB_OFF_WIN      12'hA00
`define ETB_OFF_TRANSMIT_CONFIG    12'h106
`define ETB_OFF_TXEVT    12'h128
`define ETB_OFF_BUFFER_CONFIG   12'h10A
`define ETB_OFF_BUFEVT   12'h12C
`define ETB_IO_DATA      4'h0
`define ETB_IO_TRANSMIT_COMMAND     4'h4
`define ETB_IO_TXLEN     4'h6
`define ETB_IO_ISQ       4'h8
`define ETB_IO_PTR       4'hA
`define ETB_IO_PDATA     4'hC
`define ETB_BIT_BIDERR   7
`define ETB_BIT_RDYNOW   8
`define ETB_BIT_SPACE    8
`define ETB_BIT_UNDER    9
`define ETB_BIT_ABORT    8
`define ETB_BIT_NOCRC    12
`define ETB_BIT_NOPAD    13
`define ETB_BIT_OK       8
`define ETB_BIT_LATE     9
`define ETB_BIT_JAB      10
`define ETB_BIT_COLL16   15
`define ETB_BIT_START    6
`define ETB_LEN_MIN      16'h0003
`define ETB_LEN_PAD      16'h003C
`define ETB_LEN_STD      16'h05EA
`define ETB_LEN_MAX      16'h05EE
`define ETB_START_A      16'h0005
`define ETB_START_B      16'h017D
`define ETB_START_C      16'h03FD
`endif

// file: verilog/etb_pkg.sv
// shared types of the transmit request path
package etb_pkg;
	typedef enum logic [4:0]
	{
		ST_IDLE  = 5'b00001,
		ST_CMD   = 5'b00010,
		ST_BID   = 5'b00100,
		ST_WAIT  = 5'b01000,
		ST_FILL  = 5'b10000
	} etb_state_e;
	typedef enum logic [5:0]
	{
		H_IDLE  = 6'b000001,
		H_CMD   = 6'b000010,
		H_LEN   = 6'b000100,
		H_POLL  = 6'b001000,
		H_DATA  = 6'b010000,
		H_ISQ   = 6'b100000
	} etb_host_e;
endpackage

// file: verilog/etb_if.sv
// bus between host and controller
`timescale 1ns/1ns
`default_nettype none
interface etb_if;
	logic        io_mode;
	logic [11:0] addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        irq;
	modport dev (input io_mode, addr, wdata, wr, rd, output rdata, irq);
	modport host (output io_mode, addr, wdata, wr, rd, input rdata, irq);
endinterface
`default_nettype wire

// file: verilog/etb_dev.sv
// controller end: bid, length check, buffer commit, completion flags
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "etb_defs.svh"
// What this block does
// - host keeps space irq off when polling
// - host writes command before length
// - bad length drops command, sets bid error
// - status read direct or via page pointer
// - host polls until ready-now set
// - host writes frame into window or port
// - interrupt host enables space irq, waits
// - host checks queue bit 8 on interrupt
// - success sets flag, irq when enabled
// - enough space sets ready-now, or the space event when space irq is on
// - short space waits, then event or ready-now
// - commit only after bid and flag read
// - committed space blocks later frames
// - line failures end frame unsent, flagged
// - abort clears committed and queued frames
// - data runs dry after start: underrun
// - sent length from bid, pad, crc
// - pad short frames to 60, crc follows
// - no pad: send short as is
// - 1515-1518 only without crc, never beyond
// - never send under three bytes
// - start bits pick preamble threshold
// - host writes command before every frame
module etb_dev #(
	parameter int BUF_BYTES = 3072
)(
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        srst_in,
	// host bus
	etb_if.dev               bus,
	// line side
	input  wire logic        line_free_in,
	input  wire logic        line_ok_in,
	input  wire logic        line_coll16_in,
	input  wire logic        line_jabber_in,
	input  wire logic        line_late_in,
	input  wire logic        line_dry_in,
	output logic             tx_start_out,
	output logic [15:0]      tx_len_out,
	output logic             tx_crc_out
);
	typedef struct packed {
		etb_pkg::etb_state_e st;
		logic [15:0] cmd;
		logic [15:0] len;
		logic [15:0] ptr;
		logic [15:0] transmit_config;
		logic [15:0] buffer_config;
		logic [15:0] txevt;
		logic [15:0] bufevt;
		logic        biderr;
		logic        rdynow;
		logic [15:0] used;
		logic [15:0] wcnt;
		logic        sending;
		logic [15:0] rdata;
		logic        irq;
		logic        start;
		logic [15:0] slen;
		logic        scrc;
	} etb_dev_s;
	etb_dev_s r_ff;
	etb_dev_s nxt_r;

	function automatic logic len_ok(input logic [15:0] l,
		input logic nocrc);
		len_ok = (l >= `ETB_LEN_MIN) && (l <= `ETB_LEN_MAX) &&
			(nocrc || l <= `ETB_LEN_STD);
	endfunction

	function automatic logic [15:0] sent_len(input logic [15:0] l,
		input logic nopad);
		sent_len = (!nopad && l < `ETB_LEN_PAD) ? `ETB_LEN_PAD : l;
	endfunction

	logic        wr_cmd;
	logic        wr_len;
	logic        wr_dat;
	logic        rd_bus;
	logic        rd_isq;
	logic [11:0] reg_a;
	logic [15:0] bus_status;
	logic        fits;
	logic [15:0] thresh;

	always_comb
	begin
		// io mode reaches page registers through the pointer
		reg_a  = bus.io_mode ? r_ff.ptr[11:0] : bus.addr;
		wr_cmd = bus.wr && (bus.io_mode ? bus.addr[3:0] == `ETB_IO_TRANSMIT_COMMAND
			: bus.addr == `ETB_OFF_TRANSMIT_COMMAND);
		wr_len = bus.wr && (bus.io_mode ? bus.addr[3:0] == `ETB_IO_TXLEN
			: bus.addr == `ETB_OFF_TXLEN);
		wr_dat = bus.wr && (bus.io_mode ? bus.addr[3:0] == `ETB_IO_DATA
			: bus.addr >= `ETB_OFF_WIN);
		rd_bus = bus.rd && (bus.io_mode ? (bus.addr[3:0] == `ETB_IO_PDATA
			&& reg_a == `ETB_OFF_BUS_STATUS) : bus.addr == `ETB_OFF_BUS_STATUS);
		rd_isq = bus.rd && (bus.io_mode ? bus.addr[3:0] == `ETB_IO_ISQ
			: bus.addr == `ETB_OFF_ISQ);
		bus_status = 16'h0000;
		bus_status[`ETB_BIT_BIDERR] = r_ff.biderr;
		bus_status[`ETB_BIT_RDYNOW] = r_ff.rdynow;
		fits = (32'(r_ff.used) + 32'(r_ff.len) + 32'd4) <= 32'(BUF_BYTES);
		case (r_ff.cmd[`ETB_BIT_START +: 2])
			2'b00:   thresh = `ETB_START_A;
			2'b01:   thresh = `ETB_START_B;
			2'b10:   thresh = `ETB_START_C;
			default: thresh = r_ff.len;
		endcase
	end

	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.start = 1'b0;
		nxt_r.rdata = 16'h0000;
		if (bus.rd)
		begin
			if (bus.io_mode && bus.addr[3:0] == `ETB_IO_PTR)
				nxt_r.rdata = r_ff.ptr;
			else if (rd_isq)
				nxt_r.rdata = r_ff.bufevt;
			else
			begin
				case (bus.io_mode && bus.addr[3:0] != `ETB_IO_PDATA ? 12'h000
					: reg_a)
					`ETB_OFF_BUS_STATUS:  nxt_r.rdata = bus_status;
					`ETB_OFF_TRANSMIT_COMMAND:  nxt_r.rdata = r_ff.cmd;
					`ETB_OFF_TRANSMIT_CONFIG:  nxt_r.rdata = r_ff.transmit_config;
					`ETB_OFF_BUFFER_CONFIG: nxt_r.rdata = r_ff.buffer_config;
					`ETB_OFF_TXEVT:  nxt_r.rdata = r_ff.txevt;
					`ETB_OFF_BUFEVT: nxt_r.rdata = r_ff.bufevt;
					default:         nxt_r.rdata = 16'h0000;
				endcase
			end
		end
		// reading an event register clears it
		if (rd_isq || (bus.rd && reg_a == `ETB_OFF_BUFEVT))
			nxt_r.bufevt = 16'h0000;
		if (bus.rd && reg_a == `ETB_OFF_TXEVT && !rd_isq)
			nxt_r.txevt = 16'h0000;
		if (bus.wr)
		begin
			if (bus.io_mode && bus.addr[3:0] == `ETB_IO_PTR)
				nxt_r.ptr = bus.wdata;
			if (reg_a == `ETB_OFF_TRANSMIT_CONFIG && (!bus.io_mode ||
				bus.addr[3:0] == `ETB_IO_PDATA))
				nxt_r.transmit_config = bus.wdata;
			if (reg_a == `ETB_OFF_BUFFER_CONFIG && (!bus.io_mode ||
				bus.addr[3:0] == `ETB_IO_PDATA))
				nxt_r.buffer_config = bus.wdata;
		end
		case (r_ff.st)
			etb_pkg::ST_IDLE:
				if (wr_cmd)
				begin
					nxt_r.cmd = bus.wdata;
					nxt_r.st = etb_pkg::ST_CMD;
				end
			etb_pkg::ST_CMD:
				if (wr_len)
				begin
					nxt_r.len = bus.wdata;
					if (!len_ok(bus.wdata, r_ff.cmd[`ETB_BIT_NOCRC]))
					begin
						nxt_r.biderr = 1'b1;
						nxt_r.st = etb_pkg::ST_IDLE;
					end
					else
					begin
						nxt_r.biderr = 1'b0;
						nxt_r.st = etb_pkg::ST_BID;
					end
				end
				else if (wr_cmd)
					nxt_r.cmd = bus.wdata;
			etb_pkg::ST_BID:
			begin
				if (fits && !r_ff.sending)
				begin
					if (!r_ff.rdynow && !r_ff.bufevt[`ETB_BIT_SPACE])
					begin
						if (r_ff.buffer_config[`ETB_BIT_SPACE])
							nxt_r.bufevt[`ETB_BIT_SPACE] = 1'b1;
						else
							nxt_r.rdynow = 1'b1;
					end
				end
				// granted flag seen by host: commit
				if ((rd_bus && r_ff.rdynow) || (rd_isq &&
					r_ff.bufevt[`ETB_BIT_SPACE]))
				begin
					nxt_r.used = r_ff.len;
					nxt_r.wcnt = 16'h0000;
					nxt_r.st = etb_pkg::ST_FILL;
				end
			end
			etb_pkg::ST_FILL:
				if (wr_dat && r_ff.wcnt < r_ff.len)
				begin
					nxt_r.wcnt = r_ff.wcnt + 16'd2;
					if (!r_ff.sending && (r_ff.wcnt + 16'd2 >= thresh ||
						r_ff.wcnt + 16'd2 >= r_ff.len))
					begin
						nxt_r.sending = 1'b1;
						nxt_r.start = 1'b1;
						nxt_r.slen = sent_len(r_ff.len,
							r_ff.cmd[`ETB_BIT_NOPAD]);
						nxt_r.scrc = !r_ff.cmd[`ETB_BIT_NOCRC];
					end
				end
			default:
				nxt_r.st = etb_pkg::ST_IDLE;
		endcase
		if (r_ff.st == etb_pkg::ST_FILL && r_ff.sending)
		begin
			if (line_dry_in && r_ff.wcnt < r_ff.len)
			begin
				nxt_r.bufevt[`ETB_BIT_UNDER] = 1'b1;
				nxt_r.sending = 1'b0;
				nxt_r.used = 16'h0000;
				nxt_r.st = etb_pkg::ST_IDLE;
			end
			else if (line_coll16_in || line_jabber_in || line_late_in)
			begin
				nxt_r.txevt[`ETB_BIT_COLL16] = line_coll16_in;
				nxt_r.txevt[`ETB_BIT_JAB] = line_jabber_in;
				nxt_r.txevt[`ETB_BIT_LATE] = line_late_in;
				nxt_r.sending = 1'b0;
				nxt_r.used = 16'h0000;
				nxt_r.st = etb_pkg::ST_IDLE;
			end
			else if (line_ok_in && r_ff.wcnt >= r_ff.len)
			begin
				nxt_r.txevt[`ETB_BIT_OK] = 1'b1;
				nxt_r.sending = 1'b0;
				nxt_r.used = 16'h0000;
				nxt_r.st = etb_pkg::ST_IDLE;
			end
		end
		if (r_ff.st != etb_pkg::ST_CMD && wr_cmd)
			nxt_r.rdynow = 1'b0;
		if (wr_cmd && bus.wdata[`ETB_BIT_ABORT])
		begin
			nxt_r.used = 16'h0000;
			nxt_r.sending = 1'b0;
			nxt_r.rdynow = 1'b0;
			nxt_r.st = etb_pkg::ST_CMD;
		end
		if (nxt_r.st == etb_pkg::ST_FILL && r_ff.st != etb_pkg::ST_FILL)
			nxt_r.rdynow = 1'b0;
		nxt_r.irq = (r_ff.transmit_config[`ETB_BIT_OK] && nxt_r.txevt[`ETB_BIT_OK]) ||
			(r_ff.buffer_config[`ETB_BIT_SPACE] && nxt_r.bufevt[`ETB_BIT_SPACE]) ||
			(r_ff.buffer_config[`ETB_BIT_UNDER] && nxt_r.bufevt[`ETB_BIT_UNDER]);
		if (!line_free_in)
			nxt_r.start = nxt_r.start;
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			r_ff <= '0;
			r_ff.st <= etb_pkg::ST_IDLE;
		end
		else
			r_ff <= nxt_r;
	end

	assign bus.rdata    = r_ff.rdata;
	assign bus.irq      = r_ff.irq;
	assign tx_start_out = r_ff.start;
	assign tx_len_out   = r_ff.slen;
	assign tx_crc_out   = r_ff.scrc;
endmodule
`default_nettype wire

// file: verilog/etb_host.sv
// host end: issues the bid, waits for space, writes the frame
`timescale 1ns/1ns
`default_nettype none
`include "etb_defs.svh"
module etb_host (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        srst_in,
	// user side
	input  wire logic        go_in,
	input  wire logic        irq_mode_in,
	input  wire logic        io_mode_in,
	input  wire logic [15:0] cmd_in,
	input  wire logic [15:0] len_in,
	input  wire logic [15:0] data_in,
	output logic             data_take_out,
	output logic             busy_out,
	output logic             bid_err_out,
	// device bus
	etb_if.host              bus
);
	typedef struct packed {
		etb_pkg::etb_host_e st;
		logic [1:0]  sub;
		logic [15:0] cnt;
		logic [11:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
		logic        take;
		logic        busy;
		logic        err;
		logic        iom;
	} etb_host_s;
	etb_host_s r_ff;
	etb_host_s nxt_r;

	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.wr = 1'b0;
		nxt_r.rd = 1'b0;
		nxt_r.take = 1'b0;
		case (r_ff.st)
			etb_pkg::H_IDLE:
				if (go_in)
				begin
					nxt_r.iom = io_mode_in;
					nxt_r.busy = 1'b1;
					nxt_r.err = 1'b0;
					nxt_r.sub = 2'd0;
					nxt_r.st = etb_pkg::H_CMD;
				end
			etb_pkg::H_CMD:
			begin
				// space irq enable follows the chosen mode
				if (r_ff.sub == 2'd0)
				begin
					nxt_r.wr = 1'b1;
					nxt_r.addr = r_ff.iom ? 12'(`ETB_IO_PTR) : `ETB_OFF_BUFFER_CONFIG;
					nxt_r.wdata = r_ff.iom ? 16'(`ETB_OFF_BUFFER_CONFIG)
						: {7'h00, irq_mode_in, 8'h00};
					nxt_r.sub = r_ff.iom ? 2'd1 : 2'd2;
				end
				else if (r_ff.sub == 2'd1)
				begin
					nxt_r.wr = 1'b1;
					nxt_r.addr = 12'(`ETB_IO_PDATA);
					nxt_r.wdata = {7'h00, irq_mode_in, 8'h00};
					nxt_r.sub = 2'd2;
				end
				else
				begin
					nxt_r.wr = 1'b1;
					nxt_r.addr = r_ff.iom ? 12'(`ETB_IO_TRANSMIT_COMMAND) : `ETB_OFF_TRANSMIT_COMMAND;
					nxt_r.wdata = cmd_in;
					nxt_r.st = etb_pkg::H_LEN;
				end
			end
			etb_pkg::H_LEN:
			begin
				nxt_r.wr = 1'b1;
				nxt_r.addr = r_ff.iom ? 12'(`ETB_IO_TXLEN) : `ETB_OFF_TXLEN;
				nxt_r.wdata = len_in;
				nxt_r.sub = 2'd0;
				nxt_r.st = etb_pkg::H_POLL;
			end
			etb_pkg::H_POLL:
			begin
				if (r_ff.sub == 2'd0)
				begin
					if (r_ff.iom)
					begin
						nxt_r.wr = 1'b1;
						nxt_r.addr = 12'(`ETB_IO_PTR);
						nxt_r.wdata = 16'(`ETB_OFF_BUS_STATUS);
					end
					nxt_r.sub = 2'd1;
				end
				else if (r_ff.sub == 2'd1)
				begin
					nxt_r.rd = 1'b1;
					nxt_r.addr = r_ff.iom ? 12'(`ETB_IO_PDATA) : `ETB_OFF_BUS_STATUS;
					nxt_r.sub = 2'd2;
				end
				else if (r_ff.sub == 2'd2)
					nxt_r.sub = 2'd3;
				else
				begin
					nxt_r.sub = 2'd0;
					nxt_r.cnt = 16'h0000;
					if (bus.rdata[`ETB_BIT_BIDERR])
					begin
						nxt_r.err = 1'b1;
						nxt_r.busy = 1'b0;
						nxt_r.st = etb_pkg::H_IDLE;
					end
					else if (bus.rdata[`ETB_BIT_RDYNOW])
						nxt_r.st = etb_pkg::H_DATA;
					else if (r_ff.wdata == 16'h0000 || irq_mode_in)
						nxt_r.st = etb_pkg::H_ISQ;
				end
			end
			etb_pkg::H_ISQ:
			begin
				if (r_ff.sub == 2'd0 && bus.irq)
				begin
					nxt_r.rd = 1'b1;
					nxt_r.addr = r_ff.iom ? 12'(`ETB_IO_ISQ) : `ETB_OFF_ISQ;
					nxt_r.sub = 2'd1;
				end
				else if (r_ff.sub == 2'd1)
					nxt_r.sub = 2'd2;
				else if (r_ff.sub == 2'd2)
				begin
					nxt_r.sub = 2'd0;
					if (bus.rdata[`ETB_BIT_SPACE])
					begin
						nxt_r.cnt = 16'h0000;
						nxt_r.st = etb_pkg::H_DATA;
					end
				end
			end
			etb_pkg::H_DATA:
				if (r_ff.cnt < len_in)
				begin
					nxt_r.wr = 1'b1;
					nxt_r.addr = r_ff.iom ? 12'(`ETB_IO_DATA) : `ETB_OFF_WIN +
						r_ff.cnt[11:0];
					nxt_r.wdata = data_in;
					nxt_r.take = 1'b1;
					nxt_r.cnt = r_ff.cnt + 16'd2;
				end
				else
				begin
					nxt_r.busy = 1'b0;
					nxt_r.st = etb_pkg::H_IDLE;
				end
			default:
				nxt_r.st = etb_pkg::H_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			r_ff <= '0;
			r_ff.st <= etb_pkg::H_IDLE;
		end
		else
			r_ff <= nxt_r;
	end

	assign bus.io_mode     = r_ff.iom;
	assign bus.addr        = r_ff.addr;
	assign bus.wdata       = r_ff.wdata;
	assign bus.wr          = r_ff.wr;
	assign bus.rd          = r_ff.rd;
	assign data_take_out   = r_ff.take;
	assign busy_out        = r_ff.busy;
	assign bid_err_out     = r_ff.err;
endmodule
`default_nettype wire

// file: tb/etb_checker.sv
// assertions on the bus between host end and controller end
`timescale 1ns/1ns
`default_nettype none
`include "etb_defs.svh"
module etb_checker (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        srst_in,
	// bus
	input  wire logic        io_mode,
	input  wire logic [11:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	input  wire logic [15:0] rdata,
	input  wire logic        irq
);
	logic [11:0] ptr_ff;
	logic [15:0] len_ff, words_ff, bcfg_ff, tcfg_ff;
	logic        open_ff, bad_ff, grant_ff, rd_ff, quiet_ff, nocrc_ff;
	logic        cmd_w, len_w, win_w, bst_r, quiet;
	// register reached directly or through the page pointer
	function automatic logic pg(input logic [11:0] m);
		pg = io_mode ? (addr[3:0] == `ETB_IO_PDATA && ptr_ff == m)
			: addr == m;
	endfunction
	function automatic logic port(input logic [11:0] m, input logic [3:0] p);
		port = io_mode ? addr[3:0] == p : addr == m;
	endfunction
	always_comb
	begin
		cmd_w = wr && port(`ETB_OFF_TRANSMIT_COMMAND, `ETB_IO_TRANSMIT_COMMAND);
		len_w = wr && port(`ETB_OFF_TXLEN, `ETB_IO_TXLEN);
		win_w = wr && (io_mode ? addr[3:0] == `ETB_IO_DATA
			: addr >= `ETB_OFF_WIN);
		bst_r = rd && pg(`ETB_OFF_BUS_STATUS);
		quiet = bcfg_ff == 16'h0 && tcfg_ff == 16'h0;
	end
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			{ptr_ff, len_ff, words_ff, bcfg_ff, tcfg_ff} <= '0;
			{open_ff, bad_ff, grant_ff, rd_ff, quiet_ff, nocrc_ff} <= '0;
		end
		else
		begin
			rd_ff <= rd;
			quiet_ff <= quiet;
			if (wr && io_mode && addr[3:0] == `ETB_IO_PTR)
				ptr_ff <= wdata[11:0];
			if (wr && pg(`ETB_OFF_BUFFER_CONFIG))
				bcfg_ff <= wdata;
			if (wr && pg(`ETB_OFF_TRANSMIT_CONFIG))
				tcfg_ff <= wdata;
			if (rd_ff && rdata[`ETB_BIT_RDYNOW])
				grant_ff <= 1'b1;
			if (win_w)
				words_ff <= words_ff + 16'h1;
			if (len_w)
			begin
				len_ff <= wdata;
				open_ff <= 1'b0;
				bad_ff <= wdata < 16'h0003 || wdata > 16'h05EE
					|| (wdata > 16'h05EA && !nocrc_ff);
			end
			if (cmd_w)
			begin
				nocrc_ff <= wdata[`ETB_BIT_NOCRC];
				{open_ff, bad_ff, grant_ff, words_ff} <= {3'b100, 16'h0};
			end
		end
	end
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (srst_in);
	sequence s_len;
		len_w;
	endsequence
	sequence s_status;
		bst_r;
	endsequence
	len_after_cmd_a: assert property (len_w |-> open_ff)
		else $error("length written without an open command");
	status_read_a: assert property (s_len |-> ##[1:8] s_status)
		else $error("no status read after the length");
	bid_error_a: assert property (bst_r && bad_ff |=>
		rdata[`ETB_BIT_BIDERR] && !rdata[`ETB_BIT_RDYNOW])
		else $error("bad length not flagged as bid error");
	data_granted_a: assert property (win_w |-> grant_ff)
		else $error("frame data written before space was granted");
	data_bound_a: assert property (win_w |->
		{1'b0, words_ff} < (({1'b0, len_ff} + 17'h1) >> 1))
		else $error("more frame words than the length allows");
	rdata_idle_a: assert property (!rd |=> rdata == 16'h0)
		else $error("read data outside the read answer cycle");
	poll_quiet_a: assert property (quiet && quiet_ff |-> !irq)
		else $error("interrupt with all enables clear");
	irq_cause_a: assert property ($rose(irq) |-> !quiet)
		else $error("interrupt raised without an enable");
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench: host end and controller end joined over the bus
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        mclk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        go_in = 1'b0, irq_mode_in = 1'b0, io_mode_in = 1'b0;
	logic        line_ok_in = 1'b0, line_coll16_in = 1'b0;
	logic        fail = 1'b0, pend = 1'b0, s_crc = 1'b0;
	logic [15:0] cmd_in = 16'h0, len_in = 16'h0, data_in = 16'h0;
	logic [15:0] tx_len_out, s_len = 16'h0;
	logic        data_take_out, busy_out, bid_err_out, tx_start_out, tx_crc_out;
	int          bad_count = 0, checked = 0, takes = 0, starts = 0;
	int          st_takes = 0;
	// per test: command, length, {line failure, irq mode, io mode}
	// last test sets the abort bit, which also opens a fresh bid
	logic [15:0] t_cmd [12] = '{16'h00C0, 16'h0000, 16'h1040, 16'h1080,
		16'h00C0, 16'h0040, 16'h0080, 16'h10C0, 16'h0000, 16'h2080, 16'h30C0,
		16'h0100};
	logic [15:0] t_len [12] = '{16'h0064, 16'h000A, 16'h000A, 16'h05EC,
		16'h0002, 16'h05EA, 16'h05EC, 16'h05EF, 16'h003C, 16'h000A, 16'h0003,
		16'h0040};
	logic [2:0]  t_mode [12] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h0, 3'h4,
		3'h1, 3'h0, 3'h0, 3'h2, 3'h3, 3'h0};
	etb_if bus ();
	etb_dev u_etb_dev (
		.mclk_in(mclk_in), .srst_in(srst_in), .bus(bus.dev),
		.line_free_in(1'b1), .line_ok_in(line_ok_in),
		.line_coll16_in(line_coll16_in), .line_jabber_in(1'b0),
		.line_late_in(1'b0), .line_dry_in(1'b0),
		.tx_start_out(tx_start_out), .tx_len_out(tx_len_out),
		.tx_crc_out(tx_crc_out));
	etb_host u_etb_host (
		.mclk_in(mclk_in), .srst_in(srst_in), .go_in(go_in),
		.irq_mode_in(irq_mode_in), .io_mode_in(io_mode_in),
		.cmd_in(cmd_in), .len_in(len_in), .data_in(data_in),
		.data_take_out(data_take_out), .busy_out(busy_out),
		.bid_err_out(bid_err_out), .bus(bus.host));
	etb_checker u_etb_checker (
		.mclk_in(mclk_in), .srst_in(srst_in), .io_mode(bus.io_mode),
		.addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd),
		.rdata(bus.rdata), .irq(bus.irq));
	always #4 mclk_in = ~mclk_in;
	// line side: ends a started frame once the host has stopped writing
	always @(posedge mclk_in)
	begin
		line_ok_in <= 1'b0;
		line_coll16_in <= 1'b0;
		if (pend && !busy_out)
		begin
			pend <= 1'b0;
			line_ok_in <= !fail;
			line_coll16_in <= fail;
		end
		if (data_take_out)
		begin
			takes <= takes + 1;
			data_in <= data_in + 16'h0101;
		end
		if (tx_start_out)
		begin
			pend <= 1'b1;
			starts <= starts + 1;
			st_takes <= takes + int'(data_take_out);
			s_len <= tx_len_out;
			s_crc <= tx_crc_out;
		end
	end
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask
	task automatic stop_test;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one whole frame through the host end, then compare the line side
	task automatic run(input int i);
		int   n, t0, s0, thr;
		logic err;
		logic [15:0] l;
		l = t_len[i];
		err = l < 16'd3 || l > 16'd1518 || (l > 16'd1514 && !t_cmd[i][12]);
		thr = t_cmd[i][7:6] == 2'b11 ? int'(l) : t_cmd[i][7] ? 1021
			: t_cmd[i][6] ? 381 : 5;
		if (thr > int'(l))
			thr = int'(l);
		t0 = takes;
		s0 = starts;
		cmd_in <= t_cmd[i];
		len_in <= l;
		{fail, irq_mode_in, io_mode_in} <= t_mode[i];
		go_in <= 1'b1;
		@(posedge mclk_in);
		go_in <= 1'b0;
		n = 0;
		repeat (3) @(posedge mclk_in);
		while (busy_out !== 1'b0 && n < 4000)
		begin
			@(posedge mclk_in);
			n++;
		end
		chk("busy", 16'h0, {15'h0, busy_out});
		repeat (8) @(posedge mclk_in);
		chk("bid error", {15'h0, err}, {15'h0, bid_err_out});
		chk("starts", {15'h0, !err}, 16'(starts - s0));
		chk("words", err ? 16'h0 : (l + 16'h1) >> 1, 16'(takes - t0));
		if (!err)
		begin
			chk("length", !t_cmd[i][13] && l < 16'd60 ? 16'd60 : l, s_len);
			chk("crc", {15'h0, !t_cmd[i][12]}, {15'h0, s_crc});
			chk("start", 16'h1, 16'(st_takes - t0 >= (thr + 1) / 2));
		end
		$display("test %0d done", i);
	endtask
	initial
	begin
		repeat (12) @(posedge mclk_in);
		srst_in <= 1'b0;
		@(posedge mclk_in);
		for (int i = 0; i < 12; i++)
			run(i);
		stop_test;
	end
	initial
	begin
		repeat (40000) @(posedge mclk_in);
		bad_count++;
		stop_test;
	end
endmodule
`default_nettype wire
